// ==== hw/omc_pkg.sv ====
`default_nettype none
// ***************************************************************
// operation mode controller shared definitions
// ***************************************************************
package omc_pkg;
   // operating modes of the controller
   typedef enum logic [1:0] {MODE_STOP, MODE_RUN, MODE_PAUSE, MODE_DEBUG} omc_mode_e;
   // entry processing phases
   typedef enum logic [1:0] {EP_IDLE, EP_INIT, EP_CLEAR, EP_OREF} omc_phase_e;
   // restart types for data area initialisation
   localparam logic [1:0] RST_COLD = 2'h0;
   localparam logic [1:0] RST_WARM = 2'h1;
   localparam logic [1:0] RST_HOT = 2'h2;
   // mode switch pin encoding
   localparam logic [1:0] SW_STOP = 2'h0;
   localparam logic [1:0] SW_RUN = 2'h1;
   localparam logic [1:0] SW_PAUSE_REMOTE = 2'h2;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_DBG_CFG = 8'h0c;
   localparam logic [7:0] OFS_TASK_EN = 8'h10;
   localparam logic [7:0] OFS_DBG_CTRL = 8'h14;
   // field positions
   localparam int CTRL_COMM_EN = 0;
   localparam int CTRL_RESTART_LO = 1;
   localparam int CMD_SRC_NET = 2;
   localparam int ST_SW_LO = 2;
   localparam int ST_REMOTE = 4;
   localparam int ST_HALTED = 5;
   localparam int ST_REFUSED = 6;
   localparam int ST_STOP_PEND = 7;
   localparam int DBG_STEP = 0;
   localparam int DBG_BP = 1;
   localparam int DBG_DEV = 2;
   localparam int DBG_SCANS = 3;
   localparam int DBG_CNT_LO = 16;
   localparam int DBG_RESUME = 0;
   // reset values
   localparam logic RST_COMM_EN = 1'h1;
   localparam logic [1:0] RST_RESTART = RST_COLD;
   // apb request carrier
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } omc_apb_req_s;
endpackage
`default_nettype wire

// ==== hw/omc_top.sv ====
// Contract
// - always exactly one of four modes
// - run entry initialises data per restart type
// - program validity checked before run starts
// - run scans refresh io, execute, allow interrupts
// - diagnostics and communications served in every mode
// - stop refreshes io without executing program
// - stop entry clears output image, refreshes outputs
// - pause suspends, run resumes exact state
// - pause entry keeps data and images unchanged
// - debug entered only from stop
// - debug entry initialises, clears, refreshes outputs
// - debug does one io refresh per scan
// - debug halts on any enabled condition
// - debug enables interrupt tasks individually
// - four request sources accepted
// - switch moves decoded to local modes
// - pause_remote to run keeps running
// - tool requests only in remote stop
// - listed remote transitions allowed
// - listed remote transitions refused
// - comm enable clear refuses network requests
`timescale 1ns/1ps
`default_nettype none
module omc_top #(
   parameter int SCAN_W = 16,
   parameter int TASK_N = 8
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // apb slave
   input wire omc_pkg::omc_apb_req_s apb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // mode switch pins and core events
   input wire logic [1:0] mode_sw_in,
   input wire logic prog_valid_in,
   input wire logic stop_instr_in,
   input wire logic scan_done_in,
   input wire logic step_done_in,
   input wire logic bp_hit_in,
   input wire logic dev_match_in,
   // scan control to the core
   output logic [1:0] mode_out,
   output logic [1:0] restart_type_out,
   output logic init_data_out,
   output logic clear_out_image_out,
   output logic out_refresh_out,
   output logic io_refresh_out,
   output logic exec_en_out,
   output logic service_en_out,
   output logic [TASK_N-1:0] task_en_out
);
   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (SCAN_W < 2 || SCAN_W > 16) begin : g_bad_scan
      $error("SCAN_W must be 2..16");
   end
   if (TASK_N < 1 || TASK_N > 16) begin : g_bad_task
      $error("TASK_N must be 1..16");
   end

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      omc_pkg::omc_mode_e mode; // current mode
      omc_pkg::omc_phase_e phase; // entry processing step
      logic [1:0] sw_m; // switch sync first stage
      logic [1:0] sw_s; // switch sync second stage
      logic [1:0] sw_prev; // last settled position
      logic remote_en; // remote stop reached from stop
      logic stop_pend; // stop instruction seen this scan
      logic halted; // debug stopped on a condition
      logic refused; // sticky refused request flag
      logic [SCAN_W-1:0] scan_left; // debug scans remaining
      logic comm_en; // network may change mode
      logic [1:0] restart; // restart type
      logic [3:0] dbg_en; // enabled halt conditions
      logic [SCAN_W-1:0] dbg_cnt; // scans to run in debug
      logic [TASK_N-1:0] task_mask; // debug task enables
      logic pready; // apb ready
      logic pslverr; // apb error
      logic [31:0] prdata; // apb read data
      logic o_init; // data init pulse
      logic o_clear; // output image clear pulse
      logic o_oref; // output refresh pulse
      logic o_ioref; // per scan io refresh pulse
      logic o_exec; // program execution enable
      logic o_svc; // diagnostics and comm service enable
      logic [TASK_N-1:0] o_task; // interrupt task enables
   } omc_state_s;
   omc_state_s s; // registered state
   omc_state_s next_s; // next state
   logic rst_m; // reset release first stage
   logic rst_b; // synchronised reset

   // ***************************************************************
   // decoding helpers
   // ***************************************************************
   // map an offset to a register index, 7 when unmapped
   function automatic logic [2:0] omc_dec(input logic [7:0] a);
      case (a)
         omc_pkg::OFS_CTRL: omc_dec = 3'h0;
         omc_pkg::OFS_CMD: omc_dec = 3'h1;
         omc_pkg::OFS_STATUS: omc_dec = 3'h2;
         omc_pkg::OFS_DBG_CFG: omc_dec = 3'h3;
         omc_pkg::OFS_TASK_EN: omc_dec = 3'h4;
         omc_pkg::OFS_DBG_CTRL: omc_dec = 3'h5;
         default: omc_dec = 3'h7;
      endcase
   endfunction
   // tool transition table, same for both tool sources
   function automatic logic omc_tool_ok(input omc_pkg::omc_mode_e f,
                                        input omc_pkg::omc_mode_e t);
      case (f)
         omc_pkg::MODE_STOP: omc_tool_ok = (t == omc_pkg::MODE_RUN) ||
                                           (t == omc_pkg::MODE_DEBUG);
         omc_pkg::MODE_RUN: omc_tool_ok = (t == omc_pkg::MODE_PAUSE) ||
                                          (t == omc_pkg::MODE_STOP);
         omc_pkg::MODE_PAUSE: omc_tool_ok = (t == omc_pkg::MODE_RUN) ||
                                            (t == omc_pkg::MODE_STOP);
         default: omc_tool_ok = (t == omc_pkg::MODE_STOP);
      endcase
   endfunction

   // ***************************************************************
   // reset release
   // ***************************************************************
   // assert at once, release two edges later to avoid recovery hazards
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_m <= 1'b0;
         rst_b <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_b <= rst_m;
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic acc; // apb access completes this edge
      logic wr; // completing write
      logic [2:0] idx; // decoded register
      logic req; // a mode change is requested
      logic local_req; // request from switch or stop instruction
      logic net_src; // tool request came over the network
      omc_pkg::omc_mode_e tgt; // requested mode
      logic ok; // request accepted
      acc = apb_in.psel && apb_in.penable && s.pready;
      wr = acc && apb_in.pwrite;
      idx = omc_dec(apb_in.paddr);
      req = 1'b0;
      local_req = 1'b0;
      net_src = apb_in.pwdata[omc_pkg::CMD_SRC_NET];
      tgt = s.mode;
      ok = 1'b0;
      next_s = s;
      // switch pins pass two flops before use
      next_s.sw_m = mode_sw_in;
      next_s.sw_s = s.sw_m;
      next_s.sw_prev = s.sw_s;
      // apb handshake, one wait state
      next_s.pready = apb_in.psel && apb_in.penable && !s.pready;
      next_s.pslverr = apb_in.psel && apb_in.penable && !s.pready && (idx == 3'h7);
      next_s.prdata = 32'h0000_0000;
      // stop instruction is only meaningful while running
      if (stop_instr_in && s.mode == omc_pkg::MODE_RUN) begin
         next_s.stop_pend = 1'b1;
      end
      // request sources, switch first, then stop instruction, then tools
      if (s.sw_s != s.sw_prev) begin
         req = 1'b1;
         local_req = 1'b1;
         next_s.remote_en = 1'b0;
         case (s.sw_s)
            omc_pkg::SW_RUN: tgt = omc_pkg::MODE_RUN;
            omc_pkg::SW_STOP: tgt = omc_pkg::MODE_STOP;
            omc_pkg::SW_PAUSE_REMOTE: begin
               if (s.sw_prev == omc_pkg::SW_RUN) begin
                  tgt = omc_pkg::MODE_PAUSE;
               end else begin
                  tgt = omc_pkg::MODE_STOP;
                  next_s.remote_en = 1'b1;
               end
            end
            default: req = 1'b0; // unused code ignored
         endcase
      end else if (s.stop_pend && scan_done_in) begin
         req = 1'b1;
         local_req = 1'b1;
         tgt = omc_pkg::MODE_STOP;
      end else if (wr && idx == 3'h1) begin
         req = 1'b1;
         tgt = omc_pkg::omc_mode_e'(apb_in.pwdata[1:0]);
      end
      // gate tool requests on remote stop, enable and table
      if (req) begin
         if (local_req) begin
            ok = 1'b1;
         end else begin
            ok = s.remote_en && (!net_src || s.comm_en)
                 && omc_tool_ok(s.mode, tgt);
         end
         // debug only from stop, whatever the source
         if (tgt == omc_pkg::MODE_DEBUG && s.mode != omc_pkg::MODE_STOP) begin
            ok = 1'b0;
         end
         // run from stop or debug needs a valid program
         if (tgt == omc_pkg::MODE_RUN && (s.mode == omc_pkg::MODE_STOP ||
             s.mode == omc_pkg::MODE_DEBUG) && !prog_valid_in) begin
            ok = 1'b0;
         end
      end
      // apply accepted change with its entry processing
      if (req && ok && tgt != s.mode) begin
         next_s.mode = tgt;
         case (tgt)
            omc_pkg::MODE_RUN: begin
               // resume from pause keeps everything as it was
               if (s.mode != omc_pkg::MODE_PAUSE) begin
                  next_s.phase = omc_pkg::EP_INIT;
               end else begin
                  next_s.phase = omc_pkg::EP_IDLE;
               end
            end
            omc_pkg::MODE_STOP: begin
               next_s.phase = omc_pkg::EP_CLEAR;
               next_s.stop_pend = 1'b0;
            end
            omc_pkg::MODE_DEBUG: begin
               next_s.phase = omc_pkg::EP_INIT;
               next_s.halted = 1'b0;
               next_s.scan_left = s.dbg_cnt;
            end
            default: next_s.phase = omc_pkg::EP_IDLE;
         endcase
      end else begin
         if (req && !ok) begin
            next_s.refused = 1'b1;
         end
         // entry steps run one per cycle
         case (s.phase)
            omc_pkg::EP_INIT: begin
               if (s.mode == omc_pkg::MODE_DEBUG) begin
                  next_s.phase = omc_pkg::EP_CLEAR;
               end else begin
                  next_s.phase = omc_pkg::EP_IDLE;
               end
            end
            omc_pkg::EP_CLEAR: next_s.phase = omc_pkg::EP_OREF;
            omc_pkg::EP_OREF: next_s.phase = omc_pkg::EP_IDLE;
            default: next_s.phase = omc_pkg::EP_IDLE;
         endcase
      end
      // register writes; hardware set above wins over a clear
      if (wr) begin
         case (idx)
            3'h0: begin
               next_s.comm_en = apb_in.pwdata[omc_pkg::CTRL_COMM_EN];
               next_s.restart = apb_in.pwdata[omc_pkg::CTRL_RESTART_LO +: 2];
            end
            3'h2: begin
               if (apb_in.pwdata[omc_pkg::ST_REFUSED] && !(req && !ok)) begin
                  next_s.refused = 1'b0;
               end
            end
            3'h3: begin
               next_s.dbg_en = apb_in.pwdata[3:0];
               next_s.dbg_cnt = apb_in.pwdata[omc_pkg::DBG_CNT_LO +: SCAN_W];
            end
            3'h4: next_s.task_mask = apb_in.pwdata[TASK_N-1:0];
            3'h5: begin
               if (apb_in.pwdata[omc_pkg::DBG_RESUME]) begin
                  next_s.halted = 1'b0;
                  next_s.scan_left = s.dbg_cnt;
               end
            end
            default: next_s.pslverr = 1'b0; // nothing stored
         endcase
      end
      // debug halt conditions, any enabled one stops execution
      if (s.mode == omc_pkg::MODE_DEBUG && next_s.mode == omc_pkg::MODE_DEBUG &&
          s.phase == omc_pkg::EP_IDLE && !s.halted) begin
         if (scan_done_in) begin
            next_s.scan_left = s.scan_left - 1'b1;
         end
         if ((s.dbg_en[omc_pkg::DBG_STEP] && step_done_in) ||
             (s.dbg_en[omc_pkg::DBG_BP] && bp_hit_in) ||
             (s.dbg_en[omc_pkg::DBG_DEV] && dev_match_in) ||
             (s.dbg_en[omc_pkg::DBG_SCANS] && scan_done_in &&
              s.scan_left <= SCAN_W'(1))) begin
            next_s.halted = 1'b1;
         end
      end
      // read data, captured with the ready
      if (apb_in.psel && apb_in.penable && !s.pready) begin
         case (idx)
            3'h0: next_s.prdata = {29'h0, s.restart, s.comm_en};
            3'h2: next_s.prdata = {24'h0, s.stop_pend, s.refused, s.halted,
                                   s.remote_en, s.sw_s, s.mode};
            3'h3: next_s.prdata = 32'({s.dbg_cnt, 12'h0, s.dbg_en});
            3'h4: next_s.prdata = {(32 - TASK_N)'(0), s.task_mask};
            default: next_s.prdata = 32'h0000_0000; // command, debug control and unmapped
         endcase
      end
      // outputs, registered from the next state
      next_s.o_init = (next_s.phase == omc_pkg::EP_INIT);
      next_s.o_clear = (next_s.phase == omc_pkg::EP_CLEAR);
      next_s.o_oref = (next_s.phase == omc_pkg::EP_OREF);
      // io refresh once per scan in every mode
      next_s.o_ioref = scan_done_in && (next_s.phase == omc_pkg::EP_IDLE);
      next_s.o_exec = (next_s.phase == omc_pkg::EP_IDLE) &&
                      ((next_s.mode == omc_pkg::MODE_RUN) ||
                       (next_s.mode == omc_pkg::MODE_DEBUG && !next_s.halted));
      next_s.o_svc = 1'b1;
      case (next_s.mode)
         omc_pkg::MODE_RUN: next_s.o_task = '1;
         omc_pkg::MODE_DEBUG: next_s.o_task = next_s.task_mask;
         default: next_s.o_task = '0;
      endcase
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   // reset puts the controller in stop with outputs quiet
   always_ff @(posedge core_clk_in or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.mode <= omc_pkg::MODE_STOP;
         s.comm_en <= omc_pkg::RST_COMM_EN;
         s.restart <= omc_pkg::RST_RESTART;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign prdata_out = s.prdata;
   assign pready_out = s.pready;
   assign pslverr_out = s.pslverr;
   assign mode_out = s.mode;
   assign restart_type_out = s.restart;
   assign init_data_out = s.o_init;
   assign clear_out_image_out = s.o_clear;
   assign out_refresh_out = s.o_oref;
   assign io_refresh_out = s.o_ioref;
   assign exec_en_out = s.o_exec;
   assign service_en_out = s.o_svc;
   assign task_en_out = s.o_task;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in || !rst_b);
   mode_legal_a: assert property (s.mode inside {omc_pkg::MODE_STOP, omc_pkg::MODE_RUN,
      omc_pkg::MODE_PAUSE, omc_pkg::MODE_DEBUG}) else $error("mode out of range");
   stop_entry_a: assert property (s.mode == omc_pkg::MODE_STOP &&
      $past(s.mode) != omc_pkg::MODE_STOP |-> clear_out_image_out ##1 out_refresh_out)
      else $error("stop entry missed clear or refresh");
   stop_noexec_a: assert property (s.mode == omc_pkg::MODE_STOP |-> !exec_en_out)
      else $error("program runs in stop");
   debug_from_a: assert property ($changed(s.mode) &&
      s.mode == omc_pkg::MODE_DEBUG |-> $past(s.mode) == omc_pkg::MODE_STOP)
      else $error("debug entered from other than stop");
   debug_entry_a: assert property ($changed(s.mode) &&
      s.mode == omc_pkg::MODE_DEBUG |-> init_data_out ##1 clear_out_image_out
      ##1 out_refresh_out) else $error("debug entry sequence wrong");
   pause_keep_a: assert property (s.mode == omc_pkg::MODE_PAUSE |->
      !init_data_out && !clear_out_image_out && !exec_en_out)
      else $error("pause disturbed state");
   resume_a: assert property ($past(s.mode) == omc_pkg::MODE_PAUSE &&
      s.mode == omc_pkg::MODE_RUN |-> !init_data_out && exec_en_out)
      else $error("resume did not continue");
   remote_gate_a: assert property (apb_in.psel && apb_in.penable && s.pready &&
      apb_in.pwrite && apb_in.paddr == omc_pkg::OFS_CMD && !s.remote_en &&
      s.sw_s == s.sw_prev && !(s.stop_pend && scan_done_in) |=> $stable(s.mode))
      else $error("tool request honoured outside remote stop");
   halt_step_a: assert property (s.mode == omc_pkg::MODE_DEBUG && exec_en_out &&
      s.dbg_en[omc_pkg::DBG_STEP] && step_done_in && s.sw_s == s.sw_prev
      |=> !exec_en_out[*2]) else $error("step did not halt");
   run_ioref_a: assert property (s.mode == omc_pkg::MODE_RUN &&
      s.phase == omc_pkg::EP_IDLE && scan_done_in && s.sw_s == s.sw_prev && !s.stop_pend
      && !(apb_in.psel && apb_in.penable && apb_in.pwrite && s.pready) |=> io_refresh_out)
      else $error("run scan missed io refresh");
endmodule // omc_top
`default_nettype wire

// ==== test/omc_plant_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// plant model: mode switch contacts, scan timing, stop instruction
// ***************************************************************
module omc_plant_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // requests from the bench
   input wire logic [1:0] sw_pos_in,
   input wire logic stop_req_in,
   input wire logic exec_en_in,
   // pins seen by the controller
   output logic [1:0] mode_sw_out,
   output logic scan_done_out,
   output logic stop_instr_out
);
   logic [2:0] scan_cnt; // short fixed scan keeps the run brief
   // contacts follow the lever; a scan ends every eight cycles
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scan_cnt <= 3'h0;
         scan_done_out <= 1'b0;
         stop_instr_out <= 1'b0;
         mode_sw_out <= 2'h0;
      end else begin
         mode_sw_out <= sw_pos_in;
         scan_cnt <= scan_cnt + 3'h1;
         scan_done_out <= (scan_cnt == 3'h7);
         // the instruction only executes while the program runs
         stop_instr_out <= stop_req_in && exec_en_in && (scan_cnt == 3'h3);
      end
   end
endmodule // omc_plant_model
`default_nettype wire

// ==== test/omc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module omc_top_tb;
   logic clk = 0, rst_b = 0, prog_valid = 1, step_done = 0, bp_hit = 0, dev_match = 0;
   logic stop_req = 0, scan_done, stop_instr, pready_out, pslverr_out, err;
   logic [1:0] sw_pos = 2'h0, mode_sw, mode_out, rst_type;
   logic init_o, clr_o, oref_o, io_o, exec_en_out, service_en_out;
   logic [7:0] task_en;
   logic [31:0] prdata_out, rd;
   omc_pkg::omc_apb_req_s apb_req = '0;
   int n_mismatch = 0, num_checks = 0, cyc = 0, n_init = 0, n_clr = 0, n_oref = 0, n_io = 0, b;
   // ***************************************************************
   // clock, reset and instances
   // ***************************************************************
   initial begin
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
   end
   omc_plant_model plant (.clk_in(clk), .rst_b_in(rst_b), .sw_pos_in(sw_pos),
      .stop_req_in(stop_req), .exec_en_in(exec_en_out), .mode_sw_out(mode_sw),
      .scan_done_out(scan_done), .stop_instr_out(stop_instr));
   omc_top #(.SCAN_W(16), .TASK_N(8)) dut (.core_clk_in(clk), .rst_b_in(rst_b),
      .apb_in(apb_req), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .mode_sw_in(mode_sw), .prog_valid_in(prog_valid),
      .stop_instr_in(stop_instr), .scan_done_in(scan_done), .step_done_in(step_done),
      .bp_hit_in(bp_hit), .dev_match_in(dev_match), .mode_out(mode_out),
      .restart_type_out(rst_type), .init_data_out(init_o), .clear_out_image_out(clr_o),
      .out_refresh_out(oref_o), .io_refresh_out(io_o), .exec_en_out(exec_en_out),
      .service_en_out(service_en_out), .task_en_out(task_en));
   // pulse tallies, so one-cycle strobes are never missed; also the hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      n_init <= n_init + int'(init_o === 1'b1);
      n_clr <= n_clr + int'(clr_o === 1'b1);
      n_oref <= n_oref + int'(oref_o === 1'b1);
      n_io <= n_io + int'(io_o === 1'b1);
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end
   // ***************************************************************
   // bus and helper tasks
   // ***************************************************************
   // apb transfer: setup, then access held until pready is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      @(posedge clk);
      while (pready_out !== 1'b1) @(posedge clk);
      rd = prdata_out;
      err = pslverr_out;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge clk);
   endtask
   // mode command; src bit 2 picks the network path
   task automatic cmd(input logic [2:0] c, input logic [1:0] m);
      bus(1'b1, omc_pkg::OFS_CMD, {29'h0, c});
      repeat (6) @(posedge clk);
      `CHK("mode", m, mode_out)
   endtask
   // refused flag is sticky; read then clear it
   task automatic refused(input logic e);
      bus(1'b0, omc_pkg::OFS_STATUS, 32'h0);
      `CHK("refused", e, rd[omc_pkg::ST_REFUSED])
      bus(1'b1, omc_pkg::OFS_STATUS, 32'h40);
   endtask
   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset_state();
      bus(1'b0, omc_pkg::OFS_CTRL, 32'h0);
      `CHK("ctrl", 32'h1, rd)
      `CHK("mode", 2'h0, mode_out)
      `CHK("service", 1'b1, service_en_out)
      bus(1'b0, 8'h40, 32'h0);
      `CHK("slverr", 1'b1, err)
      b = n_io;
      repeat (32) @(posedge clk);
      `CHK("stop io", 1'b1, (n_io - b >= 3) && (n_io - b <= 5))
      cmd(3'h1, 2'h0);
      refused(1'b1);
   endtask
   task automatic t_remote();
      sw_pos <= omc_pkg::SW_PAUSE_REMOTE;
      repeat (8) @(posedge clk);
      cmd(3'h2, 2'h0);
      refused(1'b1);
      b = n_init;
      cmd(3'h1, 2'h1);
      `CHK("run init", 1, n_init - b)
      `CHK("exec", 1'b1, exec_en_out)
      `CHK("tasks", 8'hff, task_en)
      refused(1'b0);
      cmd(3'h3, 2'h1);
      refused(1'b1);
      cmd(3'h2, 2'h2);
      `CHK("pause exec", 1'b0, exec_en_out)
      cmd(3'h1, 2'h1);
      `CHK("resume init", 1, n_init - b)
      b = n_clr;
      cmd(3'h0, 2'h0);
      `CHK("stop clear", 1, n_clr - b)
   endtask
   task automatic t_gating();
      bus(1'b1, omc_pkg::OFS_CTRL, 32'h0);
      cmd(3'h5, 2'h0);
      refused(1'b1);
      bus(1'b1, omc_pkg::OFS_CTRL, 32'h5);
      `CHK("restart", omc_pkg::RST_HOT, rst_type)
      prog_valid <= 1'b0;
      cmd(3'h1, 2'h0);
      refused(1'b1);
      prog_valid <= 1'b1;
   endtask
   task automatic t_debug();
      bus(1'b1, omc_pkg::OFS_DBG_CFG, 32'h1);
      bus(1'b1, omc_pkg::OFS_TASK_EN, 32'h5a);
      b = n_oref;
      cmd(3'h3, 2'h3);
      `CHK("dbg oref", 1, n_oref - b)
      `CHK("dbg tasks", 8'h5a, task_en)
      b = n_io;
      repeat (32) @(posedge clk);
      `CHK("dbg io", 1'b1, (n_io - b >= 3) && (n_io - b <= 5))
      `CHK("dbg exec", 1'b1, exec_en_out)
      step_done <= 1'b1;
      @(posedge clk);
      step_done <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("halt", 1'b0, exec_en_out)
      // scan count of three: still running after two scans, halted after three
      bus(1'b1, omc_pkg::OFS_DBG_CFG, 32'h0003_0008);
      bus(1'b1, omc_pkg::OFS_DBG_CTRL, 32'h1);
      repeat (12) @(posedge clk);
      `CHK("scan run", 1'b1, exec_en_out)
      repeat (18) @(posedge clk);
      `CHK("scan halt", 1'b0, exec_en_out)
      // breakpoint and device match, each after a resume
      bus(1'b1, omc_pkg::OFS_DBG_CFG, 32'h6);
      bus(1'b1, omc_pkg::OFS_DBG_CTRL, 32'h1);
      bp_hit <= 1'b1;
      @(posedge clk);
      bp_hit <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("bp halt", 1'b0, exec_en_out)
      bus(1'b1, omc_pkg::OFS_DBG_CTRL, 32'h1);
      dev_match <= 1'b1;
      @(posedge clk);
      dev_match <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("dev halt", 1'b0, exec_en_out)
      cmd(3'h0, 2'h0);
   endtask
   task automatic t_switch();
      cmd(3'h1, 2'h1);
      b = n_init;
      sw_pos <= omc_pkg::SW_RUN;
      repeat (8) @(posedge clk);
      `CHK("sw run", 2'h1, mode_out)
      `CHK("no reinit", 0, n_init - b)
      sw_pos <= omc_pkg::SW_PAUSE_REMOTE;
      repeat (8) @(posedge clk);
      `CHK("sw pause", 2'h2, mode_out)
      sw_pos <= omc_pkg::SW_RUN;
      repeat (8) @(posedge clk);
      `CHK("sw run2", 2'h1, mode_out)
      stop_req <= 1'b1;
      repeat (24) @(posedge clk);
      `CHK("stop instr", 2'h0, mode_out)
      stop_req <= 1'b0;
   endtask
   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      t_reset_state();
      t_remote();
      t_gating();
      t_debug();
      t_switch();
      results();
   end
endmodule // omc_top_tb
`default_nettype wire
